/* sor_pkg.sv */
package sor_pkg;
	// ==========================================================
	// Index/data port pair
	localparam logic [15:0] SOR_IDX_PORT      = 16'h0022;
	localparam logic [15:0] SOR_DATA_PORT     = 16'h0023;
	// ==========================================================
	// Register indices
	localparam logic [7:0]  SOR_USER_LOW_IDX  = 8'h4A;
	localparam logic [7:0]  SOR_USER_HIGH_IDX = 8'h4B;
	localparam logic [7:0]  SOR_PCI_CLK_IDX   = 8'h4C;
	localparam logic [7:0]  SOR_HOST_CLK_IDX  = 8'h5F;
	// ==========================================================
	// Field positions
	localparam int          SOR_PCI_DIV_BIT   = 1;
	localparam int          SOR_PCI_WR_BIT    = 4;
	localparam int          SOR_HFREQ_LSB     = 3;
	localparam int          SOR_CORE_PIN      = 40;
	localparam int          SOR_PIN23         = 23;
	// ==========================================================
	// Reset values and timing
	localparam logic [7:0]  SOR_REG_RST       = 8'h00;
	localparam logic [1:0]  SOR_DIV2_LAST     = 2'h1;
	localparam logic [1:0]  SOR_DIV3_LAST     = 2'h2;
	localparam int          SOR_RST_OUT_CYC   = 16;

	// Host clock synthesizer frequency in MHz per strap code
	function automatic logic [7:0] sor_host_mhz(input logic [2:0] code);
		case (code)
			3'h0: sor_host_mhz = 8'h19;
			3'h1: sor_host_mhz = 8'h21;
			3'h2: sor_host_mhz = 8'h28;
			3'h3: sor_host_mhz = 8'h32;
			3'h4: sor_host_mhz = 8'h3C;
			3'h5: sor_host_mhz = 8'h42;
			3'h6: sor_host_mhz = 8'h4B;
			default: sor_host_mhz = 8'h50;
		endcase
	endfunction
endpackage

/* sor_strap_regs.sv */
`timescale 1ns/1ps
module sor_strap_regs import sor_pkg::*; #(
	parameter int STRAP_W     = 41,
	parameter int RST_OUT_CYC = SOR_RST_OUT_CYC
) (
	// Clock and reset
	input  wire logic               clk_sys_in,
	input  wire logic               rst_b_in,
	// Strap pins and system reset pins
	input  wire logic [STRAP_W-1:0] memory_data_strap_pins_in,
	input  wire logic               system_reset_in_n_in,
	output logic                    system_reset_out_n_out,
	// Index/data I/O port
	input  wire logic [15:0]        io_addr_in,
	input  wire logic               io_wr_in,
	input  wire logic               io_rd_in,
	input  wire logic [7:0]         io_wdata_in,
	output logic [7:0]              io_rdata_out,
	// Hardware settings
	output logic                    pci_clk_out,
	output logic [2:0]              host_clk_sel_out,
	output logic [7:0]              host_clk_mhz_out,
	output logic                    core_single_speed_mode_out,
	output logic                    core_double_speed_mode_out
);
	// ==========================================================
	// Pin synchronisers
	logic [STRAP_W-1:0] pins_m_q;
	logic [STRAP_W-1:0] pins_q;
	logic               sysrst_m_q;
	logic               sysrst_q;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			pins_m_q   <= '0;
			pins_q     <= '0;
			sysrst_m_q <= 1'b0;
			sysrst_q   <= 1'b0;
		end else begin
			pins_m_q   <= memory_data_strap_pins_in;
			pins_q     <= pins_m_q;
			sysrst_m_q <= system_reset_in_n_in;
			sysrst_q   <= sysrst_m_q;
		end
	end

	// ==========================================================
	// Reset output sequencing; board keeps straps still until it rises
	logic [15:0] rst_cnt_q;
	logic        rst_out_q;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in || !sysrst_q) begin
			rst_cnt_q <= 16'h0000;
			rst_out_q <= 1'b0;
		end else if (rst_cnt_q == 16'(RST_OUT_CYC - 1)) begin
			rst_out_q <= 1'b1;
		end else begin
			rst_cnt_q <= rst_cnt_q + 16'h0001;
		end
	end

	// ==========================================================
	// Index port
	logic [7:0] index_q;
	wire        data_wr = io_wr_in && (io_addr_in == SOR_DATA_PORT);

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in)
			index_q <= SOR_REG_RST;
		else if (io_wr_in && io_addr_in == SOR_IDX_PORT)
			index_q <= io_wdata_in;
	end

	// ==========================================================
	// Strap registers: capture continuously while reset input is low
	logic [7:0] user_strap_low_q;
	logic [7:0] user_strap_high_q;
	logic [7:0] pci_clock_strap_q;
	logic [7:0] host_clock_strap_q;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			user_strap_low_q   <= SOR_REG_RST;
			user_strap_high_q  <= SOR_REG_RST;
			host_clock_strap_q <= SOR_REG_RST;
		end else if (!sysrst_q) begin
			// Host clock strap bits 7..6 are reserved and read back as zero
			user_strap_low_q   <= pins_q[7:0];
			user_strap_high_q  <= pins_q[15:8];
			host_clock_strap_q <= {2'b00, pins_q[26:21]};
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in)
			pci_clock_strap_q <= SOR_REG_RST;
		else if (!sysrst_q)
			pci_clock_strap_q <= {2'b00, pins_q[SOR_PIN23],
				pins_q[20:16]};
		else if (data_wr && index_q == SOR_PCI_CLK_IDX)
			pci_clock_strap_q[SOR_PCI_WR_BIT] <=
				io_wdata_in[SOR_PCI_WR_BIT];
	end

	// ==========================================================
	// Read path; no state changes on a read
	function automatic logic [7:0] rd_mux(input logic [7:0] idx,
		input logic [7:0] r0, input logic [7:0] r1,
		input logic [7:0] r2, input logic [7:0] r3);
		case (idx)
			SOR_USER_LOW_IDX:  rd_mux = r0;
			SOR_USER_HIGH_IDX: rd_mux = r1;
			SOR_PCI_CLK_IDX:   rd_mux = r2;
			SOR_HOST_CLK_IDX:  rd_mux = r3;
			default:           rd_mux = 8'h00;
		endcase
	endfunction

	logic [7:0] rdata_q;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in)
			rdata_q <= 8'h00;
		else if (io_rd_in && io_addr_in == SOR_IDX_PORT)
			rdata_q <= index_q;
		else if (io_rd_in && io_addr_in == SOR_DATA_PORT)
			rdata_q <= rd_mux(index_q, user_strap_low_q,
				user_strap_high_q, pci_clock_strap_q,
				host_clock_strap_q);
	end

	// ==========================================================
	// PCI clock divider; /3 gives a one-third duty cycle
	logic [1:0] pci_cnt_q;
	logic       pci_clk_q;
	wire        div3 = pci_clock_strap_q[SOR_PCI_DIV_BIT];
	wire        pci_wrap = pci_cnt_q >= (div3 ? SOR_DIV3_LAST
		: SOR_DIV2_LAST);

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			pci_cnt_q <= 2'h0;
			pci_clk_q <= 1'b0;
		end else begin
			pci_cnt_q <= pci_wrap ? 2'h0 : pci_cnt_q + 2'h1;
			pci_clk_q <= pci_wrap;
		end
	end

	// ==========================================================
	// Host clock and core speed settings
	logic [2:0] hsel_q;
	logic [7:0] hmhz_q;
	logic       core_x2_q;
	// Own flop for single speed so both mode outputs leave registers
	logic       core_x1_q;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			hsel_q    <= 3'h0;
			hmhz_q    <= 8'h00;
			core_x2_q <= 1'b0;
			core_x1_q <= 1'b1;
		end else begin
			hsel_q    <= host_clock_strap_q[SOR_HFREQ_LSB +: 3];
			hmhz_q    <= sor_host_mhz(
				host_clock_strap_q[SOR_HFREQ_LSB +: 3]);
			if (!sysrst_q) begin
				core_x2_q <= pins_q[SOR_CORE_PIN];
				core_x1_q <= !pins_q[SOR_CORE_PIN];
			end
		end
	end

	// User straps (speed/type) drive no hardware here.
	assign system_reset_out_n_out     = rst_out_q;
	assign io_rdata_out               = rdata_q;
	assign pci_clk_out                = pci_clk_q;
	assign host_clk_sel_out           = hsel_q;
	assign host_clk_mhz_out           = hmhz_q;
	assign core_double_speed_mode_out = core_x2_q;
	assign core_single_speed_mode_out = core_x1_q;

	// ==========================================================
	// Checks
	user_low_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!sysrst_q |=> user_strap_low_q == $past(pins_q[7:0]))
		else $error("user low strap not captured");
	user_high_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!sysrst_q |=> user_strap_high_q == $past(pins_q[15:8]))
		else $error("user high strap not captured");
	pci_capture_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!sysrst_q |=> pci_clock_strap_q[5:0] ==
			{$past(pins_q[23]), $past(pins_q[20:16])})
		else $error("pci strap not captured");
	wr_mask_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		sysrst_q && data_wr |=> {pci_clock_strap_q[7:5],
			pci_clock_strap_q[3:0]} == {$past(pci_clock_strap_q[7:5]),
			$past(pci_clock_strap_q[3:0])})
		else $error("read-only strap bit changed");
	pci_div3_a: assert property (
		@(posedge clk_sys_in)
		disable iff (!rst_b_in || !sysrst_q)
		pci_clk_q && div3 && $past(div3) |=>
			!pci_clk_q ##1 !pci_clk_q ##1 pci_clk_q)
		else $error("pci clock not host/3");
	pci_div2_a: assert property (
		@(posedge clk_sys_in)
		disable iff (!rst_b_in || !sysrst_q)
		pci_clk_q && !div3 && $past(!div3) |=> !pci_clk_q ##1 pci_clk_q)
		else $error("pci clock not host/2");
	// First edge after reset release still shows the cleared output
	host_freq_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		$past(rst_b_in) |->
			hmhz_q == sor_host_mhz($past(host_clock_strap_q[5:3])))
		else $error("host frequency mismatch");
	host_capture_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!sysrst_q |=> host_clock_strap_q == {2'b00, $past(pins_q[26:21])})
		else $error("host strap not captured");
	core_mode_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!sysrst_q |=> core_x2_q == $past(pins_q[40]) &&
			core_single_speed_mode_out != core_double_speed_mode_out)
		else $error("core mode mismatch");
	data_read_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		io_rd_in && io_addr_in == SOR_DATA_PORT |=> rdata_q ==
			rd_mux($past(index_q), $past(user_strap_low_q),
			$past(user_strap_high_q), $past(pci_clock_strap_q),
			$past(host_clock_strap_q)))
		else $error("data port read mismatch");
	rst_out_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!sysrst_q |=> !rst_out_q)
		else $error("reset out high during reset in");
	read_clean_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		sysrst_q && io_rd_in && !io_wr_in |=> $stable(index_q) &&
			$stable(pci_clock_strap_q))
		else $error("read changed state");
endmodule

/* sor_strap_board.sv */
`timescale 1ns/1ps
// ==========================================================
// Board strap resistors
module sor_strap_board (
	// Levels fitted on the user straps
	input  wire logic [40:0] level_in,
	// Strap pins seen by the device
	output logic [40:0]      pins_out
);
	// Reserved straps carry fixed resistors, so they never float
	assign pins_out = {level_in[40], 13'h1E40, level_in[26:0]};
endmodule

/* test_strap_option_registers.sv */
`timescale 1ns/1ps
module test_strap_option_registers import sor_pkg::*;;
	// ==========================================================
	// Signals
	logic        clk_sys_in;
	logic        rst_b_in;
	logic        sys_rst_n;
	logic        io_wr;
	logic        io_rd;
	logic        pci_clk;
	logic        rst_out_n;
	logic        single_out;
	logic        double_out;
	logic [15:0] io_addr;
	logic [7:0]  io_wdata;
	logic [7:0]  rdata;
	logic [7:0]  mhz;
	logic [7:0]  got;
	logic [7:0]  exp_pc;
	logic [2:0]  sel;
	logic [40:0] level;
	logic [40:0] pins;
	logic [40:0] p;
	int          n_fail = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          cnt;
	localparam logic [7:0] MHZ [8] = '{8'h19, 8'h21, 8'h28, 8'h32,
		8'h3C, 8'h42, 8'h4B, 8'h50};

	sor_strap_board board (.level_in(level), .pins_out(pins));
	// Short reset-out delay keeps each capture round brief
	sor_strap_regs #(.RST_OUT_CYC(2)) uut (
		.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.memory_data_strap_pins_in(pins),
		.system_reset_in_n_in(sys_rst_n),
		.system_reset_out_n_out(rst_out_n),
		.io_addr_in(io_addr), .io_wr_in(io_wr), .io_rd_in(io_rd),
		.io_wdata_in(io_wdata), .io_rdata_out(rdata),
		.pci_clk_out(pci_clk), .host_clk_sel_out(sel),
		.host_clk_mhz_out(mhz),
		.core_single_speed_mode_out(single_out),
		.core_double_speed_mode_out(double_out));

	// ==========================================================
	// Clock, watchdog and reporting
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// ==========================================================
	// Index/data port accesses
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_sys_in);
		io_addr  <= SOR_IDX_PORT;
		io_wdata <= idx;
		io_wr    <= 1'b1;
		@(posedge clk_sys_in);
		io_addr  <= SOR_DATA_PORT;
		io_wdata <= d;
		@(posedge clk_sys_in);
		io_wr    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
		@(posedge clk_sys_in);
		io_addr  <= SOR_IDX_PORT;
		io_wdata <= idx;
		io_wr    <= 1'b1;
		@(posedge clk_sys_in);
		io_wr    <= 1'b0;
		io_rd    <= 1'b1;
		io_addr  <= SOR_DATA_PORT;
		@(posedge clk_sys_in);
		io_rd    <= 1'b0;
		@(negedge clk_sys_in);
		d = rdata;
	endtask

	// ==========================================================
	// Main sequence: one capture round per host clock code
	initial begin
		rst_b_in  = 1'b0;
		sys_rst_n = 1'b0;
		io_wr     = 1'b0;
		io_rd     = 1'b0;
		io_addr   = 16'h0000;
		io_wdata  = 8'h00;
		level     = 41'h0;
		repeat (8) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			p = 41'h1_55_AA_F0_0F;
			p[26:24] = i[2:0];
			p[17] = i[0];
			p[40] = i[1];
			p[23] = i[2];
			p[7:0] = p[7:0] ^ 8'(i * 37);
			exp_pc = {2'h0, p[23], p[20:16]};
			@(posedge clk_sys_in);
			sys_rst_n <= 1'b0;
			level <= p;
			repeat (6) @(posedge clk_sys_in);
			chk({7'h00, rst_out_n}, 8'h00);
			sys_rst_n <= 1'b1;
			for (cnt = 0; cnt < 100 && rst_out_n !== 1'b1; cnt++)
				@(posedge clk_sys_in);
			chk({7'h00, rst_out_n}, 8'h01);
			// Pins may move now; the captured copy must not
			level <= ~p;
			repeat (4) @(posedge clk_sys_in);
			rd_reg(SOR_USER_LOW_IDX, got);
			chk(got, p[7:0]);
			rd_reg(SOR_USER_HIGH_IDX, got);
			chk(got, p[15:8]);
			rd_reg(SOR_PCI_CLK_IDX, got);
			chk(got, exp_pc);
			rd_reg(SOR_HOST_CLK_IDX, got);
			chk(got, {2'h0, p[26:21]});
			rd_reg(8'h50, got);
			chk(got, 8'h00);
			chk({5'h00, sel}, {5'h00, p[26:24]});
			chk(mhz, MHZ[i]);
			got = {6'h00, double_out, single_out};
			chk(got, {6'h00, p[40], !p[40]});
			cnt = 0;
			repeat (6) begin
				@(negedge clk_sys_in);
				cnt += int'(pci_clk);
			end
			chk(8'(cnt), p[17] ? 8'h02 : 8'h03);
			wr_reg(SOR_PCI_CLK_IDX, 8'hFF);
			rd_reg(SOR_PCI_CLK_IDX, got);
			chk(got, exp_pc | 8'h10);
			wr_reg(SOR_PCI_CLK_IDX, 8'h00);
			rd_reg(SOR_PCI_CLK_IDX, got);
			chk(got, exp_pc & 8'hEF);
			wr_reg(SOR_USER_LOW_IDX, ~p[7:0]);
			rd_reg(SOR_USER_LOW_IDX, got);
			chk(got, p[7:0]);
			// Index port reads back the index last written
			@(posedge clk_sys_in);
			io_addr <= SOR_IDX_PORT;
			io_rd   <= 1'b1;
			@(posedge clk_sys_in);
			io_rd   <= 1'b0;
			@(negedge clk_sys_in);
			chk(rdata, SOR_USER_LOW_IDX);
		end
		close_out();
	end
endmodule
